// File: rtl/mmu_check_defs.svh
// named offsets, field positions, codes and reset values of the access checker
`ifndef MMU_CHECK_DEFS_SVH
`define MMU_CHECK_DEFS_SVH

`define OFS_DOMAIN_CODES 4'h0
`define OFS_CONTROL 4'h4
`define OFS_LAST_FAULT 4'h8
`define ADDR_DECODE_MSB 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define DOMAIN_CODES_RESET 32'h00000000
`define CONTROL_RESET 32'h00000000
`define CTL_TRANSLATE_BIT 0
`define CTL_ALIGN_BIT 1
`define CTL_SYS_PROTECT_BIT 8
`define CTL_ROM_PROTECT_BIT 9
`define CONTROL_WRITE_MASK 32'h00000303

`define DOM_NO_ACCESS 2'h0
`define DOM_CLIENT 2'h1
`define DOM_RESERVED 2'h2
`define DOM_MANAGER 2'h3

`define AP_PROTECT_BITS 2'h0
`define AP_PRIV_ONLY 2'h1
`define AP_USER_READ 2'h2
`define AP_FULL 2'h3

`define DESC_INVALID 2'h0
`define L1_SECTION 2'h2
`define L2_LARGE 2'h1
`define L2_SMALL 2'h2
`define L2_TINY 2'h3
`define L1_DOMAIN_LSB 5
`define SECTION_AP_LSB 10
`define PAGE_AP_LSB 4
`define SMALL_QUARTER_LSB 10
`define LARGE_QUARTER_LSB 14

`define FS_ALIGN 4'h1
`define FS_TRANS_SECTION 4'h5
`define FS_TRANS_PAGE 4'h7
`define FS_DOMAIN_SECTION 4'h9
`define FS_DOMAIN_PAGE 4'hb
`define FS_PERM_SECTION 4'hd
`define FS_PERM_PAGE 4'hf
`define FS_NONE 4'h0

`endif

// File: rtl/mmu_check_pkg.sv
// types shared by the access checker and its bench
package mmu_check_pkg;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD
  } size_e;

  typedef struct packed {
    logic valid;
    logic [31:0] address;
    logic isWrite;
    logic isUser;
    logic isInstr;
    size_e size;
    logic [31:0] level1;
    logic [31:0] level2;
  } access_req_s;

  typedef struct packed {
    logic valid;
    logic abort;
    logic [3:0] faultStatusCode;
    logic [3:0] domain;
  } check_result_s;

endpackage

// File: rtl/mmu_access_fault_checker.sv
// access fault checker: alignment, translation, domain and permission checks
//
// Notes on behaviour
// - sixteen 2-bit domain codes live in one 32-bit register.
// - domain code 00 faults every access to that domain.
// - domain code 01 checks access against descriptor permission bits.
// - reserved domain code 10 behaves exactly like no access.
// - domain code 11 skips the permission check entirely.
// - permission meaning depends on system and rom protect bits 8 and 9.
// - protect-bit permission code with both bits clear faults everything.
// - system protect only: privileged reads allowed, all else faults.
// - rom protect only: reads allowed in both modes, writes fault.
// - privileged-only code allows privileged access, faults all user access.
// - user read-only code faults user writes only.
// - fully open code permits everything in both modes.
// - alignment enable faults misaligned word and halfword data, translation off too.
// - no alignment fault for instruction fetches or byte accesses.
// - a misaligned access aborts at once, skipping later checks.
// - descriptor low bits 00 mean invalid: section or page translation fault.
// - level one 4-bit domain number selects the domain code.
// - domain faults report section or page kind by mapping.
// - section client access decided by section field, section permission fault.
// - large/small pages use quarter fields; top quarter selects field three.
// - large/small page refusals are reported as page permission faults.
// - tiny pages use one field, refusals are page permission faults.
// - only the highest priority fault is reported.
// - faults are reported as 4-bit status code plus domain number.
// - translation, domain, permission faults only with translation enabled.
`timescale 1ns/1ps
`include "mmu_check_defs.svh"

module mmu_access_fault_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire mmu_check_pkg::access_req_s accessReq,
  output mmu_check_pkg::check_result_s checkResult
);

  // ******************************************************
  // register state
  // ******************************************************
  logic [31:0] domainAccessCodes;
  logic [31:0] control;
  logic [31:0] lastFault;
  logic [31:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic awHave;
  logic wHave;

  wire translateOn = control[`CTL_TRANSLATE_BIT];
  wire alignOn = control[`CTL_ALIGN_BIT];
  wire sysProtect = control[`CTL_SYS_PROTECT_BIT];
  wire romProtect = control[`CTL_ROM_PROTECT_BIT];

  // ******************************************************
  // decoding helpers
  // ******************************************************
  function automatic logic [3:0] reg_index(input logic [31:0] addr);
    reg_index = addr[`ADDR_DECODE_MSB:0];
  endfunction

  function automatic logic reg_mapped(input logic [31:0] addr);
    reg_mapped = (addr[31:`ADDR_DECODE_MSB+1] == '0) &&
                 (reg_index(addr) == `OFS_DOMAIN_CODES ||
                  reg_index(addr) == `OFS_CONTROL ||
                  reg_index(addr) == `OFS_LAST_FAULT);
  endfunction

  function automatic logic [31:0] strobe_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
    logic [31:0] merged;
    merged = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[8*i +: 8] = data[8*i +: 8];
      end
    end
    strobe_merge = merged;
  endfunction

  // permission decision for one 2-bit field
  function automatic logic perm_allowed(input logic [1:0] ap, input logic sysP,
                                        input logic romP, input logic user,
                                        input logic write);
    unique case (ap)
      `AP_PROTECT_BITS: begin
        unique case ({sysP, romP})
          2'h0: perm_allowed = 1'b0;
          2'h2: perm_allowed = !user && !write;
          2'h1: perm_allowed = !write;
          2'h3: perm_allowed = 1'b0;
        endcase
      end
      `AP_PRIV_ONLY: perm_allowed = !user;
      `AP_USER_READ: perm_allowed = !(user && write);
      `AP_FULL: perm_allowed = 1'b1;
    endcase
  endfunction

  // ******************************************************
  // fault evaluation
  // ******************************************************
  logic misaligned;
  logic isSection;
  logic [3:0] domainNum;
  logic [1:0] domainCode;
  logic [1:0] apSelected;
  logic [1:0] quarter;
  logic [3:0] next_code;
  logic next_abort;

  always_comb begin
    // byte accesses and fetches are never alignment checked
    misaligned = 1'b0;
    if (alignOn && !accessReq.isInstr) begin
      if (accessReq.size == mmu_check_pkg::SIZE_WORD) begin
        misaligned = accessReq.address[1:0] != 2'h0;
      end else if (accessReq.size == mmu_check_pkg::SIZE_HALF) begin
        misaligned = accessReq.address[0];
      end
    end
  end

  always_comb begin
    isSection = accessReq.level1[1:0] == `L1_SECTION;
    domainNum = accessReq.level1[`L1_DOMAIN_LSB +: 4];
    domainCode = domainAccessCodes[{domainNum, 1'b0} +: 2];
    quarter = (accessReq.level2[1:0] == `L2_LARGE) ?
              accessReq.address[`LARGE_QUARTER_LSB +: 2] :
              accessReq.address[`SMALL_QUARTER_LSB +: 2];
    if (isSection) begin
      apSelected = accessReq.level1[`SECTION_AP_LSB +: 2];
    end else if (accessReq.level2[1:0] == `L2_TINY) begin
      apSelected = accessReq.level2[`PAGE_AP_LSB +: 2];
    end else begin
      apSelected = accessReq.level2[`PAGE_AP_LSB + 2*quarter +: 2];
    end
  end

  // priority: alignment, translation, domain, permission
  always_comb begin
    next_abort = 1'b1;
    next_code = `FS_NONE;
    if (misaligned) begin
      next_code = `FS_ALIGN;
    end else if (!translateOn) begin
      next_abort = 1'b0;
    end else if (accessReq.level1[1:0] == `DESC_INVALID) begin
      next_code = `FS_TRANS_SECTION;
    end else if (!isSection && accessReq.level2[1:0] == `DESC_INVALID) begin
      next_code = `FS_TRANS_PAGE;
    end else if (domainCode == `DOM_NO_ACCESS || domainCode == `DOM_RESERVED) begin
      next_code = isSection ? `FS_DOMAIN_SECTION : `FS_DOMAIN_PAGE;
    end else if (domainCode == `DOM_CLIENT &&
                 !perm_allowed(apSelected, sysProtect, romProtect,
                               accessReq.isUser, accessReq.isWrite)) begin
      next_code = isSection ? `FS_PERM_SECTION : `FS_PERM_PAGE;
    end else begin
      next_abort = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      checkResult <= '0;
    end else begin
      checkResult.valid <= accessReq.valid;
      checkResult.abort <= accessReq.valid && next_abort;
      checkResult.faultStatusCode <= accessReq.valid ? next_code : `FS_NONE;
      checkResult.domain <= accessReq.valid ? domainNum : 4'h0;
    end
  end

  // most recent data abort, visible to software
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lastFault <= 32'h00000000;
    end else if (accessReq.valid && next_abort && !accessReq.isInstr) begin
      lastFault <= {24'h000000, domainNum, next_code};
    end
  end

  // ******************************************************
  // bus slave: write side
  // ******************************************************
  wire writeGo = awHave && wHave && !bvalid;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awHave <= 1'b0;
      awready <= 1'b1;
      awAddrHeld <= 32'h00000000;
    end else if (awvalid && awready) begin
      awHave <= 1'b1;
      awready <= 1'b0;
      awAddrHeld <= awaddr;
    end else if (writeGo) begin
      awHave <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wHave <= 1'b0;
      wready <= 1'b1;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
    end else if (wvalid && wready) begin
      wHave <= 1'b1;
      wready <= 1'b0;
      wDataHeld <= wdata;
      wStrbHeld <= wstrb;
    end else if (writeGo) begin
      wHave <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (writeGo) begin
      bvalid <= 1'b1;
      bresp <= reg_mapped(awAddrHeld) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      domainAccessCodes <= `DOMAIN_CODES_RESET;
      control <= `CONTROL_RESET;
    end else if (writeGo && reg_mapped(awAddrHeld)) begin
      if (reg_index(awAddrHeld) == `OFS_DOMAIN_CODES) begin
        domainAccessCodes <= strobe_merge(domainAccessCodes, wDataHeld, wStrbHeld);
      end else if (reg_index(awAddrHeld) == `OFS_CONTROL) begin
        control <= strobe_merge(control, wDataHeld, wStrbHeld) & `CONTROL_WRITE_MASK;
      end
    end
  end

  // ******************************************************
  // bus slave: read side
  // ******************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= reg_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (!reg_mapped(araddr)) begin
        rdata <= 32'h00000000;
      end else if (reg_index(araddr) == `OFS_DOMAIN_CODES) begin
        rdata <= domainAccessCodes;
      end else if (reg_index(araddr) == `OFS_CONTROL) begin
        rdata <= control;
      end else begin
        rdata <= lastFault;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  a_align_code: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && misaligned) |=> (checkResult.abort &&
      checkResult.faultStatusCode == `FS_ALIGN))
    else $error("misaligned access not reported as alignment fault");

  a_fetch_aligned: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && (accessReq.isInstr || accessReq.size == mmu_check_pkg::SIZE_BYTE))
      |=> checkResult.faultStatusCode != `FS_ALIGN)
    else $error("alignment fault on fetch or byte access");

  a_mmu_off: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && !translateOn && !misaligned) |=> !checkResult.abort)
    else $error("abort with translation disabled");

  a_domain_fault: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && translateOn && !misaligned && isSection &&
      !domainCode[0]) |=> checkResult.faultStatusCode == `FS_DOMAIN_SECTION)
    else $error("no-access domain not reported as section domain fault");

  a_manager_free: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && domainCode == `DOM_MANAGER) |=>
      (checkResult.faultStatusCode != `FS_PERM_SECTION &&
       checkResult.faultStatusCode != `FS_PERM_PAGE))
    else $error("permission fault in manager domain");

  a_open_code: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && translateOn && !misaligned && isSection &&
      domainCode == `DOM_CLIENT && apSelected == `AP_FULL) |=> !checkResult.abort)
    else $error("fully open permission code aborted");

  a_user_priv: assert property (@(posedge clock) disable iff (!resetn)
    (accessReq.valid && translateOn && !misaligned && isSection && accessReq.isUser &&
      domainCode == `DOM_CLIENT && apSelected == `AP_PRIV_ONLY) |=>
      checkResult.faultStatusCode == `FS_PERM_SECTION)
    else $error("user access to privileged-only section not faulted");

  a_result_tracks: assert property (@(posedge clock) disable iff (!resetn)
    checkResult.abort |-> (checkResult.valid &&
      checkResult.domain == $past(domainNum) && checkResult.faultStatusCode != `FS_NONE))
    else $error("abort without matching status or domain");

  a_control_write: assert property (@(posedge clock) disable iff (!resetn)
    (writeGo && reg_mapped(awAddrHeld) && reg_index(awAddrHeld) == `OFS_CONTROL &&
      wStrbHeld[1]) |=> sysProtect == $past(wDataHeld[`CTL_SYS_PROTECT_BIT]))
    else $error("system protect bit not updated by control write");

endmodule // mmu_access_fault_checker

// File: testbench/core_access_model.sv
// processor core model: issues one access and collects its check result
`timescale 1ns/1ps

module core_access_model (
  input wire logic clock,
  output mmu_check_pkg::access_req_s accessReq,
  input wire mmu_check_pkg::check_result_s checkResult
);
  initial accessReq = '0;

  // idle fields carry the inverse of the last access so stale values never pass
  task automatic issue(input mmu_check_pkg::access_req_s r,
                       output mmu_check_pkg::check_result_s res);
    mmu_check_pkg::access_req_s idle;
    idle = ~r;
    idle.valid = 1'b0;
    @(posedge clock);
    accessReq <= r;
    @(posedge clock);
    accessReq <= idle;
    #1 res = checkResult;
  endtask
endmodule // core_access_model

// File: testbench/tb_mmu_access_fault_checker.sv
// self-checking bench of the access fault checker
`timescale 1ns/1ps

module tb_mmu_access_fault_checker;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  mmu_check_pkg::access_req_s accessReq;
  mmu_check_pkg::check_result_s checkResult;
  int nFail = 0;
  int comparisons = 0;

  always #2 clock = ~clock;

  mmu_access_fault_checker i_mmu_access_fault_checker (
    .clock(clock), .resetn(resetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .accessReq(accessReq), .checkResult(checkResult));

  core_access_model i_core_access_model (
    .clock(clock), .accessReq(accessReq), .checkResult(checkResult));

  // ***************************************
  // shared tasks
  // ***************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask

  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    // no local limit: only the watchdog may end a wait for the response
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        done = 1'b1;
        check("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    check("bdone", 32'h1, {31'h0, done});
  endtask

  task automatic axiRead(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
        check("rdata", ed, rdata);
        check("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
    check("rdone", 32'h1, {31'h0, done});
  endtask

  task automatic access(input logic [31:0] adr, input logic wr, input logic usr,
                        input logic ins, input mmu_check_pkg::size_e sz, input logic [31:0] l1,
                        input logic [31:0] l2, input logic [3:0] code);
    mmu_check_pkg::access_req_s r;
    mmu_check_pkg::check_result_s res;
    r = '{1'b1, adr, wr, usr, ins, sz, l1, l2};
    i_core_access_model.issue(r, res);
    check("valid", 32'h1, {31'h0, res.valid});
    check("abort", {31'h0, code != 4'h0}, {31'h0, res.abort});
    check("faultCode", {28'h0, code}, {28'h0, res.faultStatusCode});
    check("domain", {28'h0, l1[8:5]}, {28'h0, res.domain});
  endtask

  function automatic logic allowed(input logic [1:0] ap, input logic [1:0] sr,
                                   input logic usr, input logic wr);
    case (ap)
      2'h3: return 1'b1;
      2'h2: return !(usr && wr);
      2'h1: return !usr;
      default: return (sr == 2'h2) ? (!usr && !wr) : (sr == 2'h1) ? !wr : 1'b0;
    endcase
  endfunction

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    $display("MISMATCH watchdog expected finish seen hang");
    nFail++;
    printVerdict();
  end

  // ***************************************
  // tests
  // ***************************************
  initial begin
    logic [31:0] l1, l2;
    logic [3:0] code;
    repeat (4) @(posedge clock);
    check("resetResult", 32'h0, {22'h0, checkResult});
    resetn <= 1'b1;
    axiRead(32'h0, 32'h0, 2'h0);
    axiRead(32'h4, 32'h0, 2'h0);
    axiRead(32'h8, 32'h0, 2'h0);
    axiRead(32'hc, 32'h0, 2'h2);
    axiWrite(32'hc, 32'h1, 2'h2);
    axiWrite(32'h4, 32'hffffffff, 2'h0);
    axiRead(32'h4, 32'h00000303, 2'h0);
    // domains 0..3 hold no access, client, reserved, manager
    axiWrite(32'h0, 32'h000000e4, 2'h0);
    axiRead(32'h0, 32'h000000e4, 2'h0);
    // alignment only, translation off: invalid descriptors give no fault
    axiWrite(32'h4, 32'h2, 2'h0);
    access(32'h1, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0, 32'h0, 4'h1);
    access(32'h2, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0, 32'h0, 4'h1);
    access(32'h1, 1, 1, 0, mmu_check_pkg::SIZE_HALF, 32'h0, 32'h0, 4'h1);
    access(32'h2, 0, 0, 0, mmu_check_pkg::SIZE_HALF, 32'h0, 32'h0, 4'h0);
    access(32'h3, 0, 0, 0, mmu_check_pkg::SIZE_BYTE, 32'h0, 32'h0, 4'h0);
    access(32'h2, 0, 0, 1, mmu_check_pkg::SIZE_WORD, 32'h0, 32'h0, 4'h0);
    axiWrite(32'h4, 32'h3, 2'h0);
    // misaligned beats invalid descriptor and no-access domain
    access(32'h1, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0, 32'h0, 4'h1);
    access(32'h0, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0, 32'h0, 4'h5);
    access(32'h0, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h1, 32'h0, 4'h7);
    access(32'h0, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0402, 32'h0, 4'h9);
    access(32'h0, 0, 0, 0, mmu_check_pkg::SIZE_WORD, 32'h0c42, 32'hff, 4'h9);
    axiRead(32'h8, 32'h00000029, 2'h0);
    access(32'h0, 0, 0, 1, mmu_check_pkg::SIZE_WORD, 32'h0002, 32'h0, 4'h9);
    axiRead(32'h8, 32'h00000029, 2'h0);
    access(32'h0, 1, 1, 0, mmu_check_pkg::SIZE_WORD, 32'h0001, 32'hf3, 4'hb);
    access(32'h0, 1, 1, 0, mmu_check_pkg::SIZE_WORD, 32'h0041, 32'h01, 4'hb);
    // client permission table over sections, large, small and tiny pages
    for (int sr = 0; sr < 4; sr++) begin
      axiWrite(32'h4, {22'h0, sr[0], sr[1], 8'h01}, 2'h0);
      for (int m = 0; m < 4; m++) begin
        for (int k = 0; k < 16; k++) begin
          // client domain 1 sits at level one bits 8:5 for both mapping kinds
          l1 = (m == 0) ? {20'h0, k[3:2], 1'b0, 4'h1, 5'h02} : {23'h0, 4'h1, 5'h01};
          l2 = {20'h0, {4{~k[3:2]}}, 2'h0, 2'(m)};
          if (m == 3) l2[5:4] = k[3:2];
          else l2[4 + 2 * k[1:0] +: 2] = k[3:2];
          code = allowed(k[3:2], 2'(sr), k[1], k[0]) ? 4'h0 : (m == 0) ? 4'hd : 4'hf;
          access((m == 1) ? {16'h0, k[1:0], 14'h0} : {20'h0, k[1:0], 10'h0}, k[0], k[1], 0,
                 mmu_check_pkg::SIZE_WORD, l1, l2, code);
        end
      end
    end
    // manager domain skips the reserved protect combination still set
    access(32'h0, 1, 1, 0, mmu_check_pkg::SIZE_WORD, 32'h0062, 32'h0, 4'h0);
    access(32'h0, 1, 1, 0, mmu_check_pkg::SIZE_WORD, 32'h0061, 32'h01, 4'h0);
    printVerdict();
  end
endmodule // tb_mmu_access_fault_checker
